/* File: core/csms_pkg.sv */
package csms_pkg;
    // Stack bank select register layout
    localparam int          SEL_REG_WIDTH    = 4;
    localparam int          MODE_BIT_POS     = 3;
    localparam int          BANK_BIT_POS     = 0;
    localparam logic [3:0]  SEL_REG_RESET    = 4'h8;
    // Mode bit values
    localparam logic        MODE_COMPACT     = 1'b1;
    localparam logic        MODE_EXTENDED    = 1'b0;
    // Stack bytes pushed per call
    localparam logic [1:0]  PUSH_COMPACT     = 2'h2;
    localparam logic [1:0]  PUSH_EXTENDED    = 2'h3;
    // Machine cycles of the long and fast calls
    localparam logic [2:0]  LCALL_CYC_COMP   = 3'h3;
    localparam logic [2:0]  LCALL_CYC_EXT    = 3'h4;
    localparam logic [2:0]  FCALL_CYC_COMP   = 3'h2;
    localparam logic [2:0]  FCALL_CYC_EXT    = 3'h3;

    typedef enum logic [2:0] {
        CSMS_OP_OTHER   = 3'b000,
        CSMS_OP_LCALL   = 3'b001,
        CSMS_OP_FCALL   = 3'b010,
        CSMS_OP_ABR_EXT = 3'b011,
        CSMS_OP_ACALL_EXT = 3'b100
    } csms_op_e;
endpackage

/* File: core/csms_call_stack_mode_select.sv */
// Behaviour
// - Mode bit one compact, zero extended
// - Reset sets mode bit, compact mode
// - Calls push two or three bytes
// - Call cycle counts depend on mode
// - Stack bank zero or one, both modes
// - Register written by 4-bit memory instruction
// - Extended calls only after register setup
`timescale 1ns/100ps
module csms_call_stack_mode_select (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       sel_wr,
    input  wire logic [3:0] sel_wdata,
    output logic      [3:0] stack_bank_select,
    input  wire logic       op_valid,
    input  wire logic [2:0] op_code,
    output logic            extended_call_mode,
    output logic            stack_bank,
    output logic      [1:0] push_bytes,
    output logic      [2:0] exec_cycles,
    output logic            op_illegal,
    output logic            op_busy,
    output logic            op_done
);
    typedef struct packed {
        logic [3:0] sel_reg;
        logic       setup_done;
        logic [2:0] cyc_left;
        logic       done;
        logic       illegal;
        logic [1:0] push;
        logic [2:0] cycles;
    } csms_state_s;

    csms_state_s st;
    csms_state_s next_st;

    function automatic logic [2:0] call_cycles(input logic [2:0] op, input logic ext);
        if (op == 3'(csms_pkg::CSMS_OP_FCALL)) begin
            call_cycles = ext ? csms_pkg::FCALL_CYC_EXT : csms_pkg::FCALL_CYC_COMP;
        end else begin
            call_cycles = ext ? csms_pkg::LCALL_CYC_EXT : csms_pkg::LCALL_CYC_COMP;
        end
    endfunction

    logic ext_mode;
    logic is_call;
    logic is_abs;
    logic op_take;
    assign ext_mode = (st.sel_reg[csms_pkg::MODE_BIT_POS] == csms_pkg::MODE_EXTENDED);
    assign is_call  = op_code == 3'(csms_pkg::CSMS_OP_LCALL) || op_code == 3'(csms_pkg::CSMS_OP_FCALL)
                      || op_code == 3'(csms_pkg::CSMS_OP_ACALL_EXT);
    assign is_abs   = op_code == 3'(csms_pkg::CSMS_OP_ABR_EXT) || op_code == 3'(csms_pkg::CSMS_OP_ACALL_EXT);
    // Write has priority, so an op issued together with a write is dropped
    assign op_take  = op_valid && !sel_wr && !op_busy;

    always_comb begin
        next_st      = st;
        next_st.done = 1'b0;
        if (sel_wr && st.cyc_left == 3'h0) begin
            next_st.sel_reg    = sel_wdata;
            next_st.setup_done = 1'b1;
        end
        if (st.cyc_left != 3'h0) begin
            next_st.cyc_left = st.cyc_left - 3'h1;
            next_st.done     = (st.cyc_left == 3'h1);
        end else if (op_take) begin
            // Absolute-range ops are refused outside extended mode
            next_st.illegal = is_abs && !ext_mode;
            next_st.push    = 2'h0;
            next_st.cycles  = 3'h1;
            if (!(is_abs && !ext_mode) && is_call) begin
                next_st.push   = ext_mode ? csms_pkg::PUSH_EXTENDED : csms_pkg::PUSH_COMPACT;
                next_st.cycles = call_cycles(op_code, ext_mode);
            end
            next_st.cyc_left = next_st.cycles;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st         <= '0;
            st.sel_reg <= csms_pkg::SEL_REG_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign stack_bank_select  = st.sel_reg;
    assign extended_call_mode = ext_mode;
    assign stack_bank         = st.sel_reg[csms_pkg::BANK_BIT_POS];
    assign push_bytes         = st.push;
    assign exec_cycles        = st.cycles;
    assign op_illegal         = st.illegal;
    assign op_busy            = st.cyc_left != 3'h0;
    assign op_done            = st.done;

    // Reset and register access
    property p_reset_compact;
        @(posedge clk) $rose(arst_n) |-> stack_bank_select[3] == 1'b1;
    endproperty
    a_reset_compact: assert property (p_reset_compact) else $error("mode bit not set after reset");

    property p_reset_idle;
        @(posedge clk) $rose(arst_n) |-> !op_busy && !op_done && !op_illegal && push_bytes == 2'h0;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("call state not idle after reset");

    property p_write_mode;
        @(posedge clk) disable iff (!arst_n) (sel_wr && !op_busy) |=> extended_call_mode == !$past(sel_wdata[3]);
    endproperty
    a_write_mode: assert property (p_write_mode) else $error("mode does not follow bit 3");

    property p_write_reg;
        @(posedge clk) disable iff (!arst_n) (sel_wr && !op_busy) |=> stack_bank_select == $past(sel_wdata);
    endproperty
    a_write_reg: assert property (p_write_reg) else $error("register write lost");

    property p_write_busy;
        @(posedge clk) disable iff (!arst_n) (sel_wr && op_busy) |=> $stable(stack_bank_select);
    endproperty
    a_write_busy: assert property (p_write_busy) else $error("register written during a call");

    property p_write_wins;
        @(posedge clk) disable iff (!arst_n) (sel_wr && op_valid && !op_busy) |=> !op_busy && !op_done;
    endproperty
    a_write_wins: assert property (p_write_wins) else $error("op taken together with a write");

    property p_bank;
        @(posedge clk) disable iff (!arst_n) stack_bank == stack_bank_select[0];
    endproperty
    a_bank: assert property (p_bank) else $error("stack bank mismatch");

    property p_setup;
        @(posedge clk) disable iff (!arst_n) extended_call_mode |-> st.setup_done;
    endproperty
    a_setup: assert property (p_setup) else $error("extended mode without register setup");

    // Call timing: results and the busy run both start one cycle after the take, then done
    sequence s_busy_1;
        op_busy ##1 (!op_busy && op_done);
    endsequence

    sequence s_busy_2;
        op_busy [*2] ##1 (!op_busy && op_done);
    endsequence

    sequence s_busy_3;
        op_busy [*3] ##1 (!op_busy && op_done);
    endsequence

    sequence s_busy_4;
        op_busy [*4] ##1 (!op_busy && op_done);
    endsequence

    sequence s_lcall_comp;
        op_take && op_code == 3'h1 && !extended_call_mode;
    endsequence
    property p_lcall_comp;
        @(posedge clk) disable iff (!arst_n) s_lcall_comp |=> push_bytes == 2'h2 ##0 s_busy_3;
    endproperty
    a_lcall_comp: assert property (p_lcall_comp) else $error("compact long call wrong");

    sequence s_lcall_ext;
        op_take && op_code == 3'h1 && extended_call_mode;
    endsequence
    property p_lcall_ext;
        @(posedge clk) disable iff (!arst_n) s_lcall_ext |=> push_bytes == 2'h3 ##0 s_busy_4;
    endproperty
    a_lcall_ext: assert property (p_lcall_ext) else $error("extended long call wrong");

    sequence s_fcall_comp;
        op_take && op_code == 3'h2 && !extended_call_mode;
    endsequence
    property p_fcall_comp_len;
        @(posedge clk) disable iff (!arst_n) s_fcall_comp |=> push_bytes == 2'h2 ##0 s_busy_2;
    endproperty
    a_fcall_comp_len: assert property (p_fcall_comp_len) else $error("compact fast call wrong");

    sequence s_fcall_ext;
        op_take && op_code == 3'h2 && extended_call_mode;
    endsequence
    property p_fcall_ext_len;
        @(posedge clk) disable iff (!arst_n) s_fcall_ext |=> push_bytes == 2'h3 ##0 s_busy_3;
    endproperty
    a_fcall_ext_len: assert property (p_fcall_ext_len) else $error("extended fast call wrong");

    property p_fcall;
        @(posedge clk) disable iff (!arst_n) (op_valid && !sel_wr && !op_busy && op_code == 3'h2)
            |=> exec_cycles == (extended_call_mode ? 3'h3 : 3'h2);
    endproperty
    a_fcall: assert property (p_fcall) else $error("fast call cycle count wrong");

    // Absolute-range ops: a refused one still costs a busy cycle so software sees done
    property p_abs_refused;
        @(posedge clk) disable iff (!arst_n) (op_valid && !sel_wr && !op_busy && op_code[2:0] == 3'h3
            && !extended_call_mode) |=> op_illegal && push_bytes == 2'h0;
    endproperty
    a_abs_refused: assert property (p_abs_refused) else $error("absolute op ran in compact mode");

    property p_acall_refused;
        @(posedge clk) disable iff (!arst_n) (op_take && op_code == 3'h4 && !extended_call_mode)
            |=> op_illegal && push_bytes == 2'h0 ##0 s_busy_1;
    endproperty
    a_acall_refused: assert property (p_acall_refused) else $error("absolute call ran in compact mode");

    property p_abs_ext;
        @(posedge clk) disable iff (!arst_n) (op_take && op_code == 3'h3 && extended_call_mode)
            |=> !op_illegal && push_bytes == 2'h0 && exec_cycles == 3'h1;
    endproperty
    a_abs_ext: assert property (p_abs_ext) else $error("absolute branch refused in extended mode");

    property p_acall_ext;
        @(posedge clk) disable iff (!arst_n) (op_take && op_code == 3'h4 && extended_call_mode)
            |=> !op_illegal && push_bytes == 2'h3 ##0 s_busy_4;
    endproperty
    a_acall_ext: assert property (p_acall_ext) else $error("absolute call wrong in extended mode");

    property p_other;
        @(posedge clk) disable iff (!arst_n) (op_take && op_code == 3'h0)
            |=> push_bytes == 2'h0 && exec_cycles == 3'h1 && !op_illegal;
    endproperty
    a_other: assert property (p_other) else $error("plain op pushed stack bytes");

    property p_push_legal;
        @(posedge clk) disable iff (!arst_n) push_bytes != 2'h1;
    endproperty
    a_push_legal: assert property (p_push_legal) else $error("illegal stack byte count");

    property p_busy_hold;
        @(posedge clk) disable iff (!arst_n) op_busy |=> $stable(push_bytes) && $stable(exec_cycles) && $stable(op_illegal);
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("results changed during a call");

    property p_done_end;
        @(posedge clk) disable iff (!arst_n) op_done |-> !op_busy && $past(op_busy);
    endproperty
    a_done_end: assert property (p_done_end) else $error("done pulse outside end of call");
endmodule

/* File: testbench/testbench.sv */
`timescale 1ns/100ps
module testbench;
    logic       clk = 1'b0;
    logic       arst_n;
    logic       sel_wr;
    logic [3:0] sel_wdata;
    logic [3:0] bank_sel;
    logic       op_valid;
    logic [2:0] op_code;
    logic       ext;
    logic       bank;
    logic [1:0] push;
    logic [2:0] cyc_n;
    logic       ill;
    logic       busy;
    logic       done;
    int         errors;
    int         compares;
    int         cyc;
    int         n;

    csms_call_stack_mode_select csms_call_stack_mode_select_i (
        .clk(clk), .arst_n(arst_n), .sel_wr(sel_wr), .sel_wdata(sel_wdata), .stack_bank_select(bank_sel),
        .op_valid(op_valid), .op_code(op_code), .extended_call_mode(ext), .stack_bank(bank),
        .push_bytes(push), .exec_cycles(cyc_n), .op_illegal(ill), .op_busy(busy), .op_done(done));

    task automatic final_report;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] d);
        @(negedge clk);
        sel_wr = 1'b1;
        sel_wdata = d;
        @(negedge clk);
        sel_wr = 1'b0;
    endtask

    task automatic drv(input logic v, input logic [2:0] c, input logic w, input logic [3:0] d);
        @(negedge clk);
        op_valid = v;
        op_code = c;
        sel_wr = w;
        sel_wdata = d;
    endtask

    // Busy length is counted so a wrong cycle figure shows even if exec_cycles is right
    task automatic op(input logic [2:0] c, input logic [1:0] pb, input logic [2:0] ec, input logic il);
        @(negedge clk);
        op_valid = 1'b1;
        op_code = c;
        @(negedge clk);
        op_valid = 1'b0;
        n = 0;
        while (busy === 1'b1 && n < 20) begin
            n++;
            @(negedge clk);
        end
        chk("op_done", {3'h0, done}, 4'h1);
        chk("push_bytes", {2'h0, push}, {2'h0, pb});
        chk("exec_cycles", {1'h0, cyc_n}, {1'h0, ec});
        chk("op_illegal", {3'h0, ill}, {3'h0, il});
        chk("busy_len", n[3:0], {1'h0, ec});
    endtask

    initial begin
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            errors++;
            final_report();
        end
    end

    initial begin
        {arst_n, sel_wr, sel_wdata, op_valid, op_code} = '0;
        repeat (3) @(negedge clk);
        arst_n = 1'b1;
        chk("sel", bank_sel, 4'h8);
        chk("ext", {3'h0, ext}, 4'h0);
        op(3'h1, 2'h2, 3'h3, 1'b0);
        op(3'h2, 2'h2, 3'h2, 1'b0);
        op(3'h3, 2'h0, 3'h1, 1'b1);
        op(3'h4, 2'h0, 3'h1, 1'b1);
        op(3'h0, 2'h0, 3'h1, 1'b0);
        wr(4'h9);
        chk("bank", {3'h0, bank}, 4'h1);
        wr(4'h0);
        chk("sel", bank_sel, 4'h0);
        chk("ext", {3'h0, ext}, 4'h1);
        chk("bank", {3'h0, bank}, 4'h0);
        op(3'h1, 2'h3, 3'h4, 1'b0);
        op(3'h2, 2'h3, 3'h3, 1'b0);
        op(3'h3, 2'h0, 3'h1, 1'b0);
        op(3'h4, 2'h3, 3'h4, 1'b0);
        // A write while a call runs must be dropped
        drv(1'b1, 3'h1, 1'b0, 4'h0);
        drv(1'b0, 3'h0, 1'b1, 4'h8);
        drv(1'b0, 3'h0, 1'b0, 4'h8);
        chk("sel_busy", bank_sel, 4'h0);
        repeat (4) @(negedge clk);
        chk("busy_end", {3'h0, busy}, 4'h0);
        // Write and op in one idle cycle: the write lands, the op is dropped
        drv(1'b1, 3'h1, 1'b1, 4'h1);
        drv(1'b0, 3'h0, 1'b0, 4'h1);
        chk("op_dropped", {3'h0, busy}, 4'h0);
        chk("sel", bank_sel, 4'h1);
        chk("bank", {3'h0, bank}, 4'h1);
        @(negedge clk);
        arst_n = 1'b0;
        @(negedge clk);
        chk("sel_rst", bank_sel, 4'h8);
        arst_n = 1'b1;
        chk("ext_rst", {3'h0, ext}, 4'h0);
        wr(4'h8);
        op(3'h1, 2'h2, 3'h3, 1'b0);
        final_report();
    end
endmodule
